// ### pkg/audio_link_pkg.sv
// Constants shared by the audio configuration and link status register bank
package audio_link_pkg;
   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] AUDIO_CONFIGURATION_ADDR = 8'h55;
   localparam logic [7:0] LINK_STATUS_ADDR = 8'h5A;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] AUDIO_CONFIGURATION_RESET = 8'h0C;
   localparam logic [7:0] LINK_STATUS_RESET = 8'h00;
   localparam logic [7:0] READ_IDLE_VALUE = 8'h00;

   // ----------------------------------------------------------------
   // Audio configuration fields
   // ----------------------------------------------------------------
   localparam int TDM_TO_PARALLEL_BIT = 7;
   localparam int HDMI_I2S_OUT_BIT = 6;
   localparam int FIFO_RESET_ON_TYPE_BIT = 3;
   localparam int FIFO_RESET_ON_AUDIO_INFOFRAME_BIT = 2;
   localparam int FIFO_RESET_ON_VIDEO_INFOFRAME_BIT = 1;
   localparam int FIFO_RESET_ON_CLOCK_REGEN_BIT = 0;
   localparam logic [7:0] AUDIO_CONFIGURATION_WRITABLE = 8'hCF;

   // ----------------------------------------------------------------
   // Link status fields
   // ----------------------------------------------------------------
   localparam int DOWNSTREAM_LINK_READY_BIT = 7;
   localparam int SERIAL_TX_ACTIVE_BIT = 6;
   localparam int SERIAL_PORT_MODE_LSB = 4;
   localparam int TMDS_DATA_VALID_BIT = 3;
   localparam int HDMI_PLL_LOCK_BIT = 2;
   localparam int NO_HDMI_CLOCK_BIT = 1;
   localparam int INPUT_FREQUENCY_STABLE_BIT = 0;

   // ----------------------------------------------------------------
   // Encodings
   // ----------------------------------------------------------------
   localparam logic AUDIO_SOURCE_HDMI = 1'b0;
   localparam logic AUDIO_SOURCE_LOCAL = 1'b1;
   typedef enum logic [1:0] {
      PORT_MODE_DUAL = 2'h0,
      PORT_MODE_SINGLE_PORT0 = 2'h1,
      PORT_MODE_SINGLE_PORT1 = 2'h2,
      PORT_MODE_REPLICATE = 2'h3
   } port_mode_type;

   // ----------------------------------------------------------------
   // Change detection
   // ----------------------------------------------------------------
   localparam int CHANGE_SOURCES = 4;
   localparam int CHANGE_WIDTH = 40;
   localparam int AUDIO_TYPE_WIDTH = 4;
   localparam int CHECKSUM_WIDTH = 8;
   localparam int ACR_FIELD_WIDTH = 20;
   localparam int SYNC_STAGES = 2;
endpackage : audio_link_pkg

// ### pkg/link_status_if.sv
// Carrier between the register bank and the link-clock side
`timescale 1ns/100ps
interface link_status_if;
   // Link domain levels
   logic linkReady;
   logic txActive;
   logic [1:0] portMode;
   // System domain level
   logic tdmEnable;

   modport monitor (output linkReady, output txActive, output portMode, input tdmEnable);
   modport regs (input linkReady, input txActive, input portMode, output tdmEnable);
endinterface : link_status_if

// ### src/link_side_monitor.sv
// Link-clock logic: captures link state and picks the audio transmit clock
`timescale 1ns/100ps
module link_side_monitor (
   // Clock and reset
   input wire logic clk_link,
   input wire logic rstn,
   // Raw link state from the serial transmitter
   input wire logic linkDetected,
   input wire logic txLocked,
   input wire logic [1:0] txPortMode,
   // Audio clock choice, link domain
   output logic audioClkTdm_q,
   // Carrier
   link_status_if.monitor link
);
   // ----------------------------------------------------------------
   // Link state registers
   // ----------------------------------------------------------------
   logic linkReady_q;
   logic txActive_q;
   logic [1:0] portMode_q;
   logic tdmSync1_q;

   // Capture link state on its own clock
   always_ff @(posedge clk_link or negedge rstn) begin
      if (!rstn) begin
         linkReady_q <= 1'b0;
         txActive_q <= 1'b0;
         portMode_q <= audio_link_pkg::PORT_MODE_DUAL;
      end else begin
         linkReady_q <= linkDetected;
         txActive_q <= txLocked & linkDetected;
         portMode_q <= txPortMode;
      end
   end

   // Bring the conversion enable over, then steer the audio clock
   always_ff @(posedge clk_link or negedge rstn) begin
      if (!rstn) begin
         tdmSync1_q <= 1'b0;
         audioClkTdm_q <= 1'b0;
      end else begin
         tdmSync1_q <= link.tdmEnable;
         audioClkTdm_q <= tdmSync1_q;
      end
   end

   assign link.linkReady = linkReady_q;
   assign link.txActive = txActive_q;
   assign link.portMode = portMode_q;
endmodule : link_side_monitor

// ### src/audio_cfg_link_status_regs.sv
// Audio configuration and link status register bank of the serializer bridge
`timescale 1ns/100ps
module audio_cfg_link_status_regs #(
   parameter bit FIRST_REVISION = 1'b0
) (
   // Clocks and reset
   input wire logic clk_sys,
   input wire logic clk_link,
   input wire logic rstn,
   // Register access from the serial control bus slave
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWrEn,
   input wire logic regRdEn,
   output logic [7:0] regRdData_q,
   // Audio source selection from bridge configuration
   input wire logic audioSourceSel,
   // HDMI receiver health, asynchronous pins
   input wire logic tmdsDataValid,
   input wire logic hdmiPllLock,
   input wire logic noHdmiClock,
   input wire logic inputFrequencyStable,
   // HDMI stream fields with receive strobes
   input wire logic audioTypeStb,
   input wire logic [audio_link_pkg::AUDIO_TYPE_WIDTH-1:0] audioType,
   input wire logic audioInfoframeStb,
   input wire logic [audio_link_pkg::CHECKSUM_WIDTH-1:0] audioInfoframeSum,
   input wire logic videoInfoframeStb,
   input wire logic [audio_link_pkg::CHECKSUM_WIDTH-1:0] videoInfoframeSum,
   input wire logic clockRegenStb,
   input wire logic [audio_link_pkg::ACR_FIELD_WIDTH-1:0] clockRegenN,
   input wire logic [audio_link_pkg::ACR_FIELD_WIDTH-1:0] clockRegenCts,
   // Serial link state, link clock domain
   input wire logic linkDetected,
   input wire logic txLocked,
   input wire logic [1:0] txPortMode,
   // Audio controls
   output logic tdmConvEnable_q,
   output logic audioClkTdm_q,
   output logic hdmiI2sOutEnable_q,
   output logic localAudioSel_q,
   output logic audioFifoReset_q
);
   localparam int NS = audio_link_pkg::CHANGE_SOURCES;
   localparam int CW = audio_link_pkg::CHANGE_WIDTH;
   localparam int NSYNC = 7;

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   link_status_if link ();
   logic [7:0] audioCfg_q;
   logic [7:0] linkStatus;
   logic [NSYNC-1:0] syncIn;
   logic [NSYNC-1:0] syncA_q;
   logic [NSYNC-1:0] syncB_q;
   logic [NS-1:0] chgStb;
   logic [NS-1:0] chgEn;
   logic [NS-1:0] changed;
   logic [CW-1:0] chgVal [NS];

   // ----------------------------------------------------------------
   // Link-clock side
   // ----------------------------------------------------------------
   link_side_monitor linkSide (
      .clk_link(clk_link),
      .rstn(rstn),
      .linkDetected(linkDetected),
      .txLocked(txLocked),
      .txPortMode(txPortMode),
      .audioClkTdm_q(audioClkTdm_q),
      .link(link.monitor)
   );

   assign link.tdmEnable = audioCfg_q[audio_link_pkg::TDM_TO_PARALLEL_BIT];

   // ----------------------------------------------------------------
   // Register writes
   // ----------------------------------------------------------------
   // Audio configuration, reserved bits held at zero
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         audioCfg_q <= audio_link_pkg::AUDIO_CONFIGURATION_RESET;
      end else if (regWrEn && regAddr == audio_link_pkg::AUDIO_CONFIGURATION_ADDR) begin
         audioCfg_q <= regWrData & audio_link_pkg::AUDIO_CONFIGURATION_WRITABLE;
      end
   end

   // ----------------------------------------------------------------
   // Audio path controls
   // ----------------------------------------------------------------
   // Registered steering from the configuration and the audio source selection
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         tdmConvEnable_q <= 1'b0;
         hdmiI2sOutEnable_q <= 1'b0;
         localAudioSel_q <= audio_link_pkg::AUDIO_SOURCE_HDMI;
      end else begin
         tdmConvEnable_q <= audioCfg_q[audio_link_pkg::TDM_TO_PARALLEL_BIT];
         hdmiI2sOutEnable_q <= audioCfg_q[audio_link_pkg::HDMI_I2S_OUT_BIT]
            & (audioSourceSel == audio_link_pkg::AUDIO_SOURCE_HDMI);
         localAudioSel_q <= (audioSourceSel == audio_link_pkg::AUDIO_SOURCE_LOCAL);
      end
   end

   // ----------------------------------------------------------------
   // Stream change detection
   // ----------------------------------------------------------------
   // Source table: type, audio infoframe, video infoframe, N and CTS
   assign chgStb = {clockRegenStb, videoInfoframeStb, audioInfoframeStb, audioTypeStb};
   assign chgVal[0] = CW'(audioType);
   assign chgVal[1] = CW'(audioInfoframeSum);
   assign chgVal[2] = CW'(videoInfoframeSum);
   assign chgVal[3] = {clockRegenN, clockRegenCts};
   assign chgEn[0] = audioCfg_q[audio_link_pkg::FIFO_RESET_ON_TYPE_BIT];
   assign chgEn[1] = audioCfg_q[audio_link_pkg::FIFO_RESET_ON_AUDIO_INFOFRAME_BIT];
   assign chgEn[2] = audioCfg_q[audio_link_pkg::FIFO_RESET_ON_VIDEO_INFOFRAME_BIT];
   assign chgEn[3] = audioCfg_q[audio_link_pkg::FIFO_RESET_ON_CLOCK_REGEN_BIT];

   // One tracker per source; first value seen only primes the tracker
   for (genvar i = 0; i < NS; i++) begin : gChange
      logic [CW-1:0] prev_q;
      logic seen_q;
      always_ff @(posedge clk_sys or negedge rstn) begin
         if (!rstn) begin
            prev_q <= '0;
            seen_q <= 1'b0;
         end else if (chgStb[i]) begin
            prev_q <= chgVal[i];
            seen_q <= 1'b1;
         end
      end
      assign changed[i] = chgStb[i] && seen_q && (chgVal[i] != prev_q);
   end

   // FIFO reset pulse on any enabled change
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         audioFifoReset_q <= 1'b0;
      end else begin
         audioFifoReset_q <= |(changed & chgEn);
      end
   end

   // ----------------------------------------------------------------
   // Status synchronisers
   // ----------------------------------------------------------------
   assign syncIn = {link.linkReady, link.txActive, link.portMode, tmdsDataValid, hdmiPllLock, noHdmiClock};
   logic syncHdmi;
   logic syncHdmiA_q;
   logic syncHdmiB_q;
   assign syncHdmi = inputFrequencyStable;

   // Two flip-flops per crossing bit
   for (genvar b = 0; b < NSYNC; b++) begin : gSync
      always_ff @(posedge clk_sys or negedge rstn) begin
         if (!rstn) begin
            syncA_q[b] <= 1'b0;
            syncB_q[b] <= 1'b0;
         end else begin
            syncA_q[b] <= syncIn[b];
            syncB_q[b] <= syncA_q[b];
         end
      end
   end

   // Frequency stable pin, two flip-flops
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         syncHdmiA_q <= 1'b0;
         syncHdmiB_q <= 1'b0;
      end else begin
         syncHdmiA_q <= syncHdmi;
         syncHdmiB_q <= syncHdmiA_q;
      end
   end

   // ----------------------------------------------------------------
   // Status assembly
   // ----------------------------------------------------------------
   always_comb begin
      linkStatus = audio_link_pkg::LINK_STATUS_RESET;
      linkStatus[audio_link_pkg::DOWNSTREAM_LINK_READY_BIT] = syncB_q[6];
      linkStatus[audio_link_pkg::SERIAL_TX_ACTIVE_BIT] = syncB_q[5];
      if (syncB_q[5]) begin
         linkStatus[audio_link_pkg::SERIAL_PORT_MODE_LSB +: 2] = syncB_q[4:3];
      end
      linkStatus[audio_link_pkg::TMDS_DATA_VALID_BIT] = FIRST_REVISION ? 1'b1 : syncB_q[2];
      linkStatus[audio_link_pkg::HDMI_PLL_LOCK_BIT] = syncB_q[1];
      linkStatus[audio_link_pkg::NO_HDMI_CLOCK_BIT] = syncB_q[0];
      linkStatus[audio_link_pkg::INPUT_FREQUENCY_STABLE_BIT] = syncHdmiB_q;
   end

   // ----------------------------------------------------------------
   // Register reads
   // ----------------------------------------------------------------
   // Read data held until the next read; unmapped reads return zero
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         regRdData_q <= audio_link_pkg::READ_IDLE_VALUE;
      end else if (regRdEn) begin
         case (regAddr)
            audio_link_pkg::AUDIO_CONFIGURATION_ADDR: regRdData_q <= audioCfg_q;
            audio_link_pkg::LINK_STATUS_ADDR: regRdData_q <= linkStatus;
            default: regRdData_q <= audio_link_pkg::READ_IDLE_VALUE;
         endcase
      end
   end
endmodule : audio_cfg_link_status_regs

// ### tb/link_partner.sv
// Behavioural model of the serial transmitter state at the link side
`timescale 1ns/100ps
module link_partner (
   // Clock and reset
   input wire logic clk_link,
   input wire logic rstn,
   // Commanded link state
   input wire logic wantLink,
   input wire logic wantLock,
   input wire logic [1:0] wantMode,
   // Link state towards the bridge
   output logic linkDetected,
   output logic txLocked,
   output logic [1:0] txPortMode
);
   // State moves on link clock edges only; lock needs the link commanded on the same edge
   always_ff @(posedge clk_link or negedge rstn) begin
      if (!rstn) begin
         linkDetected <= 1'b0;
         txLocked <= 1'b0;
         txPortMode <= 2'h0;
      end else begin
         linkDetected <= wantLink;
         txLocked <= wantLink & wantLock;
         txPortMode <= wantMode;
      end
   end
endmodule : link_partner

// ### tb/audio_cfg_link_status_asserts.sv
// Assertions on the ports of the audio configuration and link status bank
`timescale 1ns/100ps
module audio_cfg_link_status_asserts #(
   parameter bit FIRST_REVISION = 1'b0
) (
   // Watched ports
   input wire logic clk_sys, clk_link, rstn, regWrEn, regRdEn, audioSourceSel, audioTypeStb,
   input wire logic audioInfoframeStb, videoInfoframeStb, clockRegenStb,
   input wire logic [7:0] regAddr, regWrData, regRdData_q,
   input wire logic [audio_link_pkg::AUDIO_TYPE_WIDTH-1:0] audioType,
   input wire logic tdmConvEnable_q, audioClkTdm_q, hdmiI2sOutEnable_q, localAudioSel_q, audioFifoReset_q
);
   logic [7:0] cfg_q;
   logic typeSeen_q;
   logic [audio_link_pkg::AUDIO_TYPE_WIDTH-1:0] typeLast_q;
   wire anyStb = audioTypeStb | audioInfoframeStb | videoInfoframeStb | clockRegenStb;
   wire rdStatus = regRdEn && regAddr == audio_link_pkg::LINK_STATUS_ADDR;
   // Shadow of the configuration register
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) cfg_q <= audio_link_pkg::AUDIO_CONFIGURATION_RESET;
      else if (regWrEn && regAddr == 8'h55) cfg_q <= regWrData & 8'hCF;
   end
   // Last strobed audio type
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) typeSeen_q <= 1'b0;
      else if (audioTypeStb) typeSeen_q <= 1'b1;
   end
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) typeLast_q <= '0;
      else if (audioTypeStb) typeLast_q <= audioType;
   end
   a_tdm_follows_write: assert property (@(posedge clk_sys) disable iff (!rstn)
      regWrEn && regAddr == 8'h55 ##1 !regWrEn |=> tdmConvEnable_q == $past(regWrData[7], 2))
      else $error("conversion enable does not follow write");
   a_audio_clk_follow: assert property (@(posedge clk_link) disable iff (!rstn)
      $changed(audioClkTdm_q) |-> audioClkTdm_q == tdmConvEnable_q)
      else $error("audio clock choice moved against enable");
   a_i2s_out_gated: assert property (@(posedge clk_sys) disable iff (!rstn)
      audioSourceSel |=> !hdmiI2sOutEnable_q)
      else $error("I2S output enabled with local source");
   a_local_source: assert property (@(posedge clk_sys) disable iff (!rstn)
      $past(rstn) && $changed(audioSourceSel) |=> localAudioSel_q == $past(audioSourceSel))
      else $error("source selection not applied");
   a_type_change: assert property (@(posedge clk_sys) disable iff (!rstn)
      audioTypeStb && typeSeen_q && audioType != typeLast_q && cfg_q[3] |=> audioFifoReset_q)
      else $error("no FIFO reset on type change");
   a_pulse_cause: assert property (@(posedge clk_sys) disable iff (!rstn)
      audioFifoReset_q |-> $past(anyStb) && $past(cfg_q[3:0]) != 4'h0)
      else $error("FIFO reset without enabled strobe");
   a_cfg_readback: assert property (@(posedge clk_sys) disable iff (!rstn)
      regRdEn && regAddr == 8'h55 |=> regRdData_q == $past(cfg_q))
      else $error("configuration read mismatch");
   a_read_holds: assert property (@(posedge clk_sys) disable iff (!rstn)
      !regRdEn |=> $stable(regRdData_q))
      else $error("read data moved without a read");
   a_mode_inactive: assert property (@(posedge clk_sys) disable iff (!rstn)
      rdStatus |=> regRdData_q[6] || regRdData_q[5:4] == 2'h0)
      else $error("port mode shown while inactive");
   a_tmds_first_rev: assert property (@(posedge clk_sys) disable iff (!rstn)
      rdStatus |=> !FIRST_REVISION || regRdData_q[3])
      else $error("Tmds_data_valid low on first revision");
endmodule : audio_cfg_link_status_asserts
bind audio_cfg_link_status_regs audio_cfg_link_status_asserts #(.FIRST_REVISION(FIRST_REVISION)) u_chk (
   .clk_sys(clk_sys), .clk_link(clk_link), .rstn(rstn), .regWrEn(regWrEn), .regRdEn(regRdEn),
   .audioSourceSel(audioSourceSel), .audioTypeStb(audioTypeStb), .audioInfoframeStb(audioInfoframeStb),
   .videoInfoframeStb(videoInfoframeStb), .clockRegenStb(clockRegenStb), .regAddr(regAddr),
   .regWrData(regWrData), .regRdData_q(regRdData_q), .audioType(audioType), .tdmConvEnable_q(tdmConvEnable_q),
   .audioClkTdm_q(audioClkTdm_q), .hdmiI2sOutEnable_q(hdmiI2sOutEnable_q), .localAudioSel_q(localAudioSel_q),
   .audioFifoReset_q(audioFifoReset_q));

// ### tb/test_audio_cfg_link_status_regs.sv
// Testbench of the audio configuration and link status bank
`timescale 1ns/100ps
module test_audio_cfg_link_status_regs;
   logic clk_sys = 1'b0, clk_link = 1'b0, rstn = 1'b0;
   logic regWrEn = 1'b0, regRdEn = 1'b0, audioSourceSel = 1'b0;
   logic [7:0] regAddr = 8'h00, regWrData = 8'h00, regRdData_q;
   logic tmds = 1'b0, pll = 1'b0, noClk = 1'b0, freq = 1'b0;
   logic [3:0] stb = 4'h0;
   logic [19:0] val = 20'h00000;
   logic wantLink = 1'b0, wantLock = 1'b0;
   logic [1:0] wantMode = 2'h3, txPortMode;
   logic linkDetected, txLocked, tdmConvEnable_q, audioClkTdm_q, hdmiI2sOutEnable_q, localAudioSel_q;
   logic audioFifoReset_q;
   int n_fail = 0, comparisons = 0;
   // Clocks, unrelated in phase
   initial forever #50 clk_sys = ~clk_sys;
   initial begin
      #37;
      forever #62.5 clk_link = ~clk_link;
   end
   audio_cfg_link_status_regs dut (.clk_sys(clk_sys), .clk_link(clk_link), .rstn(rstn), .regAddr(regAddr),
      .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData_q(regRdData_q),
      .audioSourceSel(audioSourceSel), .tmdsDataValid(tmds), .hdmiPllLock(pll), .noHdmiClock(noClk),
      .inputFrequencyStable(freq), .audioTypeStb(stb[0]), .audioType(val[3:0]), .audioInfoframeStb(stb[1]),
      .audioInfoframeSum(val[7:0]), .videoInfoframeStb(stb[2]), .videoInfoframeSum(val[7:0]),
      .clockRegenStb(stb[3]), .clockRegenN(val), .clockRegenCts(~val), .linkDetected(linkDetected),
      .txLocked(txLocked), .txPortMode(txPortMode), .tdmConvEnable_q(tdmConvEnable_q),
      .audioClkTdm_q(audioClkTdm_q), .hdmiI2sOutEnable_q(hdmiI2sOutEnable_q),
      .localAudioSel_q(localAudioSel_q), .audioFifoReset_q(audioFifoReset_q));
   link_partner partner (.clk_link(clk_link), .rstn(rstn), .wantLink(wantLink), .wantLock(wantLock),
      .wantMode(wantMode), .linkDetected(linkDetected), .txLocked(txLocked), .txPortMode(txPortMode));
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic chk1(input logic got, input logic exp);
      check({7'h00, got}, {7'h00, exp});
   endtask : chk1
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_sys);
      regAddr = a;
      regWrData = d;
      regWrEn = 1'b1;
      @(negedge clk_sys);
      regWrEn = 1'b0;
   endtask : wr
   task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
      @(negedge clk_sys);
      regAddr = a;
      regRdEn = 1'b1;
      @(negedge clk_sys);
      regRdEn = 1'b0;
      @(negedge clk_sys);
      check(regRdData_q, exp);
   endtask : rdChk
   // One strobe on source s; the FIFO reset pulse stands in the following cycle
   task automatic pulse(input int s, input logic [19:0] v, input logic exp);
      @(negedge clk_sys);
      val = v;
      stb[s] = 1'b1;
      @(negedge clk_sys);
      chk1(audioFifoReset_q, exp);
      stb = 4'h0;
   endtask : pulse
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : wrap_up
   // Watchdog
   initial begin
      #2000000;
      n_fail++;
      wrap_up();
   end
   // Test sequence
   initial begin
      repeat (6) @(negedge clk_sys);
      rstn = 1'b1;
      rdChk(8'h55, 8'h0C);
      rdChk(8'h5A, 8'h00);
      $display("test reset values done");
      wr(8'h55, 8'hFF);
      rdChk(8'h55, 8'hCF);
      chk1(tdmConvEnable_q, 1'b1);
      wr(8'h5A, 8'hFF);
      wr(8'h10, 8'h00);
      rdChk(8'h10, 8'h00);
      rdChk(8'h55, 8'hCF);
      chk1(audioClkTdm_q, 1'b1);
      chk1(hdmiI2sOutEnable_q, 1'b1);
      audioSourceSel = 1'b1;
      repeat (2) @(negedge clk_sys);
      chk1(hdmiI2sOutEnable_q, 1'b0);
      chk1(localAudioSel_q, 1'b1);
      audioSourceSel = 1'b0;
      wr(8'h55, 8'h00);
      repeat (10) @(negedge clk_sys);
      chk1(audioClkTdm_q, 1'b0);
      chk1(localAudioSel_q, 1'b0);
      $display("test configuration done");
      tmds = 1'b1;
      noClk = 1'b1;
      wantLink = 1'b1;
      repeat (12) @(negedge clk_sys);
      rdChk(8'h5A, 8'h8A);
      wantLock = 1'b1;
      for (int i = 0; i < 4; i++) begin
         wantMode = i[1:0];
         repeat (12) @(negedge clk_sys);
         rdChk(8'h5A, {2'b11, i[1:0], 4'hA});
      end
      {tmds, pll, noClk, freq} = 4'h5;
      wantLink = 1'b0;
      repeat (12) @(negedge clk_sys);
      rdChk(8'h5A, 8'h05);
      $display("test status done");
      for (int s = 0; s < 4; s++) begin
         wr(8'h55, 8'(8'h01 << (3 - s)));
         pulse(s, 20'h00011, 1'b0);
         pulse(s, 20'h00022, 1'b1);
         pulse(s, 20'h00022, 1'b0);
         wr(8'h55, 8'h00);
         pulse(s, 20'h00033, 1'b0);
      end
      $display("test change detect done");
      wrap_up();
   end
endmodule : test_audio_cfg_link_status_regs
